/* File: dma_pkg.sv */
// Function
// - Eight identical independently configured transfer channels.
// - Transfers use a dedicated bus, not CPU's.
// - Control bit 15 enables channel, resets clear.
// - Control bit 14 selects byte, else word.
// - Control bit 13: one means RAM to peripheral.
// - Control bit 12 moves interrupt to half block.
// - Control bit 11 adds null peripheral write when bit 13 is zero.
// - Addressing field: increment, fixed, peripheral indirect.
// - Operating field: continuous/one-shot, with/without ping-pong.
// - Ping-pong swaps buffer bases after each block.
// - Force bit starts exactly one manual transfer.
// - Force ignores written zero; hardware clears it.
// - Seven-bit select picks one of 128 requests.
// - Base writes store; reads return live pointer.
// - Simultaneous requests resolved by fixed priority.
// - Each channel raises its own completion interrupt.
// - Peripheral indirect: peripheral supplies RAM address.
// - Ten-bit transfer count defines block length.
// - Shared status: two collision flags, ping-pong bit.
// - Block length is count plus one transfers.
// - Latest channel field, 1111 until first transfer.
`default_nettype none
package dma_pkg;
	localparam int NCH = 8;
	localparam int CHW = 3;
	localparam logic [4:0] OFS_CON = 5'h00;
	localparam logic [4:0] OFS_REQ = 5'h04;
	localparam logic [4:0] OFS_STA = 5'h08;
	localparam logic [4:0] OFS_STB = 5'h0c;
	localparam logic [4:0] OFS_PAD = 5'h10;
	localparam logic [4:0] OFS_CNT = 5'h14;
	localparam logic [3:0] CH_PAGE = 4'h0;
	localparam logic [11:0] OFS_COLL = 12'h100;
	localparam logic [11:0] OFS_ACT = 12'h104;
	localparam int B_ON = 15;
	localparam int B_BYTE = 14;
	localparam int B_DIR = 13;
	localparam int B_HALF = 12;
	localparam int B_NULL = 11;
	localparam int B_AM = 4;
	localparam int B_ONE = 0;
	localparam int B_PP = 1;
	localparam int B_FORCE = 15;
	localparam logic [15:0] CON_MASK = 16'hf833;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [3:0] LAST_RST = 4'hf;
	localparam logic [1:0] AM_INC = 2'b00;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] BYTE_MASK = 16'h00ff;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READ = 4'b0010,
		ST_LATCH = 4'b0100,
		ST_WRITE = 4'b1000
	} xfer_state_e;
endpackage : dma_pkg
`default_nettype wire

/* File: prio_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter (
	input wire logic [dma_pkg::NCH-1:0] req_in,
	output logic [dma_pkg::CHW-1:0] idx_out,
	output logic any_out
);
	logic [dma_pkg::NCH-1:0] below;
	logic [dma_pkg::NCH-1:0] grant;

	assign below[0] = 1'b0;
	for (genvar i = 0; i < dma_pkg::NCH - 1; i++) begin : g_chain
		assign below[i + 1] = below[i] | req_in[i];
	end
	// Lowest channel number wins.
	assign grant = req_in & ~below;
	assign any_out = |req_in;

	always_comb begin
		idx_out = '0;
		for (int i = 0; i < dma_pkg::NCH; i++) begin
			if (grant[i]) begin
				idx_out = i[dma_pkg::CHW-1:0];
			end
		end
	end
endmodule : prio_arbiter
`default_nettype wire

/* File: xfer_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module xfer_engine (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic dir_in,
	input wire logic byte_in,
	input wire logic null_in,
	input wire logic [15:0] ram_addr_in,
	input wire logic [15:0] per_addr_in,
	input wire logic [15:0] ram_rdata_in,
	input wire logic [15:0] per_rdata_in,
	input wire logic ram_coll_in,
	input wire logic per_coll_in,
	output logic busy_out,
	output logic done_out,
	output logic ram_coll_out,
	output logic per_coll_out,
	output logic [15:0] ram_addr_out,
	output logic [15:0] per_addr_out,
	output logic [15:0] ram_wdata_out,
	output logic [15:0] per_wdata_out,
	output logic ram_rd_out,
	output logic ram_wr_out,
	output logic per_rd_out,
	output logic per_wr_out,
	output logic byte_out
);
	dma_pkg::xfer_state_e st_r, st_nxt;
	logic dir_r, null_r;
	logic [15:0] src_w;

	always_comb begin
		case (st_r)
			dma_pkg::ST_IDLE: st_nxt = start_in ? dma_pkg::ST_READ : dma_pkg::ST_IDLE;
			dma_pkg::ST_READ: st_nxt = dma_pkg::ST_LATCH;
			dma_pkg::ST_LATCH: st_nxt = dma_pkg::ST_WRITE;
			default: st_nxt = dma_pkg::ST_IDLE;
		endcase
	end

	// Read data arrives one cycle after the read strobe.
	assign src_w = (dir_r ? ram_rdata_in : per_rdata_in) & (byte_out ? dma_pkg::BYTE_MASK : 16'hffff);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r <= dma_pkg::ST_IDLE;
			{dir_r, null_r, byte_out} <= 3'h0;
			{ram_addr_out, per_addr_out} <= 32'h0000_0000;
			{ram_wdata_out, per_wdata_out} <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			if (st_r == dma_pkg::ST_IDLE && start_in) begin
				{dir_r, null_r, byte_out} <= {dir_in, null_in, byte_in};
				{ram_addr_out, per_addr_out} <= {ram_addr_in, per_addr_in};
			end
			if (st_r == dma_pkg::ST_LATCH) begin
				ram_wdata_out <= src_w;
				per_wdata_out <= null_r ? dma_pkg::REG_RST : src_w;
			end
		end
	end

	// Strobes go to the dedicated bus only.
	assign ram_rd_out = st_r == dma_pkg::ST_READ && dir_r;
	assign per_rd_out = st_r == dma_pkg::ST_READ && !dir_r;
	assign ram_wr_out = st_r == dma_pkg::ST_WRITE && !dir_r;
	assign per_wr_out = st_r == dma_pkg::ST_WRITE && (dir_r || null_r);
	assign done_out = st_r == dma_pkg::ST_WRITE;
	assign busy_out = st_r != dma_pkg::ST_IDLE;
	assign ram_coll_out = ram_wr_out && ram_coll_in;
	assign per_coll_out = per_wr_out && per_coll_in;
endmodule : xfer_engine
`default_nettype wire

/* File: eight_channel_peripheral_dma.sv */
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module eight_channel_peripheral_dma (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic [127:0] REQ_LINE_IN,
	input wire logic [15:0] PER_IND_ADDR_IN,
	input wire logic [15:0] PER_RDATA_IN,
	input wire logic [15:0] RAM_RDATA_IN,
	input wire logic PER_COLL_IN,
	input wire logic RAM_COLL_IN,
	output logic [15:0] PER_ADDR_OUT,
	output logic [15:0] PER_WDATA_OUT,
	output logic PER_RD_OUT,
	output logic PER_WR_OUT,
	output logic [15:0] RAM_ADDR_OUT,
	output logic [15:0] RAM_WDATA_OUT,
	output logic RAM_RD_OUT,
	output logic RAM_WR_OUT,
	output logic BYTE_OUT,
	output logic [7:0] CH_IRQ_OUT
);
	// ****************************************
	// Register bus decode
	// ****************************************
	wire logic setup_w = PSEL_IN && !PENABLE_IN;
	wire logic acc_w = PSEL_IN && PENABLE_IN;
	wire logic wr_w = acc_w && PWRITE_IN;
	wire logic [2:0] ch_sel = PADDR_IN[7:5];
	wire logic [4:0] ofs_w = PADDR_IN[4:0];
	wire logic page_w = PADDR_IN[11:8] == dma_pkg::CH_PAGE;
	wire logic is_con = page_w && ofs_w == dma_pkg::OFS_CON;
	wire logic is_req = page_w && ofs_w == dma_pkg::OFS_REQ;
	wire logic is_sta = page_w && ofs_w == dma_pkg::OFS_STA;
	wire logic is_stb = page_w && ofs_w == dma_pkg::OFS_STB;
	wire logic is_pad = page_w && ofs_w == dma_pkg::OFS_PAD;
	wire logic is_cnt = page_w && ofs_w == dma_pkg::OFS_CNT;
	wire logic is_coll = PADDR_IN == dma_pkg::OFS_COLL;
	wire logic is_act = PADDR_IN == dma_pkg::OFS_ACT;
	wire logic hit_w = is_con || is_req || is_sta || is_stb || is_pad || is_cnt
		|| is_coll || is_act;
	wire logic [15:0] wd_w = PWDATA_IN[15:0];

	// ****************************************
	// Channel state
	// ****************************************
	logic [15:0] con_r [8];
	logic [6:0] sel_r [8];
	logic [15:0] sta_r [8];
	logic [15:0] stb_r [8];
	logic [15:0] pad_r [8];
	logic [9:0] cnt_r [8];
	logic [15:0] ptr_r [8];
	logic [9:0] xf_r [8];
	logic [7:0] force_r;
	logic [7:0] pend_r;
	logic [7:0] pp_r;
	logic [7:0] on_w;
	logic [7:0] ch_req;
	logic [7:0] irq_w;
	logic [7:0] bend_w;
	logic [7:0] stop_w;
	logic [7:0] irq_r;
	logic [15:0] coll_r;
	logic [3:0] last_r;
	logic [2:0] cur_ch_r;
	logic [31:0] prdata_r;

	wire logic eng_done;
	wire logic eng_busy;
	wire logic ram_coll_w;
	wire logic per_coll_w;
	wire logic [2:0] arb_idx;
	wire logic arb_any;
	wire logic start_w = arb_any && !eng_busy;

	// All eight channels share one body; only their index differs.
	for (genvar i = 0; i < dma_pkg::NCH; i++) begin : g_ch
		wire logic me_w = wr_w && ch_sel == 3'(i);
		wire logic w_con = me_w && is_con;
		wire logic w_req = me_w && is_req;
		wire logic dn = eng_done && cur_ch_r == 3'(i);
		wire logic last_xf = xf_r[i] == cnt_r[i];
		wire logic half_xf = xf_r[i] == {1'b0, cnt_r[i][9:1]};
		wire logic pp_en = con_r[i][dma_pkg::B_PP];
		wire logic one_en = con_r[i][dma_pkg::B_ONE];
		wire logic bend = dn && last_xf;
		// One-shot ping-pong runs one block from each buffer, then stops.
		wire logic stop = bend && one_en && (!pp_en || pp_r[i]);
		wire logic turn_on = w_con && wd_w[dma_pkg::B_ON] && !con_r[i][dma_pkg::B_ON];
		wire logic pp_flip = bend && pp_en;
		wire logic [15:0] base = (pp_r[i] ^ pp_flip) ? stb_r[i] : sta_r[i];
		wire logic [15:0] step = con_r[i][dma_pkg::B_BYTE] ? dma_pkg::STEP_BYTE
			: dma_pkg::STEP_WORD;
		wire logic inc_en = con_r[i][5:4] == dma_pkg::AM_INC;

		assign on_w[i] = con_r[i][dma_pkg::B_ON];
		// A set force bit starts a transfer without a request.
		assign ch_req[i] = on_w[i] && (force_r[i] || pend_r[i]);
		assign irq_w[i] = dn && (con_r[i][dma_pkg::B_HALF] ? half_xf : last_xf);
		assign bend_w[i] = bend;
		assign stop_w[i] = stop;

		always_ff @(posedge CLK_IN) begin
			if (RST_IN) begin
				con_r[i] <= dma_pkg::REG_RST;
				sel_r[i] <= 7'h00;
				{sta_r[i], stb_r[i], pad_r[i], ptr_r[i]} <= 64'h0;
				{cnt_r[i], xf_r[i]} <= 20'h00000;
				{force_r[i], pend_r[i], pp_r[i]} <= 3'h0;
			end else begin
				// A software write wins over the one-shot auto clear.
				if (w_con) begin
					con_r[i] <= wd_w & dma_pkg::CON_MASK;
				end else if (stop) begin
					con_r[i][dma_pkg::B_ON] <= 1'b0;
				end
				if (w_req) begin
					sel_r[i] <= wd_w[6:0];
				end
				// Written zero is ignored; a new set beats the clear.
				force_r[i] <= (w_req && wd_w[dma_pkg::B_FORCE]) || (force_r[i] && !dn);
				// Selected line sets pending; set beats the clear.
				pend_r[i] <= (on_w[i] && REQ_LINE_IN[sel_r[i]])
					|| (pend_r[i] && !(dn && !force_r[i]));
				if (me_w && is_sta) begin
					sta_r[i] <= wd_w;
				end
				if (me_w && is_stb) begin
					stb_r[i] <= wd_w;
				end
				if (me_w && is_pad) begin
					pad_r[i] <= wd_w;
				end
				if (me_w && is_cnt) begin
					cnt_r[i] <= wd_w[9:0];
				end
				if (turn_on) begin
					ptr_r[i] <= sta_r[i];
					xf_r[i] <= 10'h000;
					pp_r[i] <= 1'b0;
				end else if (dn) begin
					// Continuous blocks reload pointer and count.
					xf_r[i] <= last_xf ? 10'h000 : xf_r[i] + 10'h001;
					pp_r[i] <= pp_r[i] ^ pp_flip;
					if (last_xf) begin
						ptr_r[i] <= base;
					end else if (inc_en) begin
						ptr_r[i] <= ptr_r[i] + step;
					end
				end
			end
		end
	end

	// ****************************************
	// Arbitration and the transaction bus
	// ****************************************
	prio_arbiter u_arb (
		.req_in(ch_req),
		.idx_out(arb_idx),
		.any_out(arb_any)
	);

	wire logic [15:0] g_con = con_r[arb_idx];
	wire logic g_dir = g_con[dma_pkg::B_DIR];
	// Peripheral indirect takes the address the peripheral offers.
	wire logic [15:0] g_ram = g_con[5] ? PER_IND_ADDR_IN : ptr_r[arb_idx];

	// The engine owns a bus of its own, so the processor never waits.
	xfer_engine u_eng (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.start_in(start_w),
		.dir_in(g_dir),
		.byte_in(g_con[dma_pkg::B_BYTE]),
		.null_in(g_con[dma_pkg::B_NULL] && !g_dir),
		.ram_addr_in(g_ram),
		.per_addr_in(pad_r[arb_idx]),
		.ram_rdata_in(RAM_RDATA_IN),
		.per_rdata_in(PER_RDATA_IN),
		.ram_coll_in(RAM_COLL_IN),
		.per_coll_in(PER_COLL_IN),
		.busy_out(eng_busy),
		.done_out(eng_done),
		.ram_coll_out(ram_coll_w),
		.per_coll_out(per_coll_w),
		.ram_addr_out(RAM_ADDR_OUT),
		.per_addr_out(PER_ADDR_OUT),
		.ram_wdata_out(RAM_WDATA_OUT),
		.per_wdata_out(PER_WDATA_OUT),
		.ram_rd_out(RAM_RD_OUT),
		.ram_wr_out(RAM_WR_OUT),
		.per_rd_out(PER_RD_OUT),
		.per_wr_out(PER_WR_OUT),
		.byte_out(BYTE_OUT)
	);

	// ****************************************
	// Shared status
	// ****************************************
	wire logic [7:0] cur_oh = 8'h01 << cur_ch_r;
	wire logic [15:0] coll_set = {per_coll_w ? cur_oh : 8'h00, ram_coll_w ? cur_oh : 8'h00};
	wire logic [15:0] coll_clr = (wr_w && is_coll) ? wd_w : 16'h0000;

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			cur_ch_r <= 3'h0;
			last_r <= dma_pkg::LAST_RST;
			coll_r <= dma_pkg::REG_RST;
			irq_r <= 8'h00;
		end else begin
			if (start_w) begin
				cur_ch_r <= arb_idx;
			end
			if (eng_done) begin
				last_r <= {1'b0, cur_ch_r};
			end
			// Writing one clears a flag; a fresh collision wins.
			coll_r <= (coll_r & ~coll_clr) | coll_set;
			irq_r <= irq_w;
		end
	end
	assign CH_IRQ_OUT = irq_r;

	// ****************************************
	// Read path
	// ****************************************
	// Base registers read back the live pointer, not the stored base.
	wire logic [15:0] rd_w = is_con ? con_r[ch_sel]
		: is_req ? {force_r[ch_sel], 8'h00, sel_r[ch_sel]}
		: (is_sta || is_stb) ? ptr_r[ch_sel]
		: is_pad ? pad_r[ch_sel]
		: is_cnt ? {6'h00, cnt_r[ch_sel]}
		: is_coll ? coll_r
		: is_act ? {4'h0, last_r, pp_r}
		: dma_pkg::REG_RST;

	// Data is captured in the setup phase so the access phase needs no wait.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup_w && !PWRITE_IN) begin
			prdata_r <= {16'h0000, rd_w};
		end
	end
	assign PRDATA_OUT = prdata_r;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = acc_w && !hit_w;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	wire logic [7:0] low_mask = (8'h01 << arb_idx) - 8'h01;

	lastch_a: assert property (eng_done |=> last_r == {1'b0, $past(cur_ch_r)})
		else $error("Latest channel not recorded.");
	prio_a: assert property (start_w |-> ch_req[arb_idx] && (ch_req & low_mask) == 8'h00)
		else $error("Grant not lowest requesting channel.");
	idle_ch_a: assert property ((ch_req & ~on_w) == 8'h00)
		else $error("Disabled channel requests service.");
	seq_a: assert property (start_w |=> (RAM_RD_OUT ^ PER_RD_OUT) ##2 (RAM_WR_OUT || PER_WR_OUT))
		else $error("Transfer sequence broken.");
	dir_wr_a: assert property (RAM_WR_OUT |-> !con_r[cur_ch_r][dma_pkg::B_DIR])
		else $error("RAM written in peripheral-bound direction.");
	null_wr_a: assert property (PER_WR_OUT && !con_r[cur_ch_r][dma_pkg::B_DIR]
		|-> PER_WDATA_OUT == 16'h0000 && RAM_WR_OUT)
		else $error("Null write wrong.");
	force_clr_a: assert property (eng_done && force_r[cur_ch_r] && !(wr_w && is_req)
		|=> !force_r[$past(cur_ch_r)])
		else $error("Force bit not cleared after transfer.");
	irq_src_a: assert property (CH_IRQ_OUT != 8'h00 |-> $past(eng_done)
		&& CH_IRQ_OUT == $past(cur_oh))
		else $error("Interrupt without a completed transfer.");
	oneshot_a: assert property (|stop_w && !(wr_w && is_con) |=> (on_w & $past(stop_w)) == 8'h00)
		else $error("One-shot channel still enabled.");
	ptr_rd_a: assert property (setup_w && !PWRITE_IN && is_sta
		|=> PRDATA_OUT[15:0] == $past(ptr_r[ch_sel]))
		else $error("Base read does not show pointer.");
	// Byte elements must never carry stale upper bits onto either bus.
	byte_data_a: assert property (BYTE_OUT && (RAM_WR_OUT || PER_WR_OUT)
		|-> RAM_WDATA_OUT[15:8] == 8'h00 && PER_WDATA_OUT[15:8] == 8'h00)
		else $error("Byte transfer carries upper bits.");
	// A read strobe and a write strobe never share a cycle on the transaction bus.
	strobe_sep_a: assert property (!((RAM_RD_OUT || PER_RD_OUT) && (RAM_WR_OUT || PER_WR_OUT)))
		else $error("Read and write strobes overlap.");
	// A continuous single-buffer channel restarts from its primary base.
	reload_a: assert property (eng_done && bend_w[cur_ch_r] && !con_r[cur_ch_r][dma_pkg::B_PP]
		&& !wr_w |=> ptr_r[$past(cur_ch_r)] == $past(sta_r[cur_ch_r]))
		else $error("Pointer not reloaded after block.");
	// Fixed addressing keeps the pointer inside a block.
	fixed_ptr_a: assert property (eng_done && !bend_w[cur_ch_r] && con_r[cur_ch_r][5:4] == 2'b01
		&& !wr_w |=> ptr_r[$past(cur_ch_r)] == $past(ptr_r[cur_ch_r]))
		else $error("Fixed pointer moved.");
	// The latest channel field only moves when a transfer finishes.
	last_hold_a: assert property (!$past(eng_done) |-> $stable(last_r))
		else $error("Latest channel changed without a transfer.");

	forced_c: cover property (eng_done && force_r[cur_ch_r]);
	pp_swap_c: cover property (|(bend_w & pp_r));
	half_c: cover property (|irq_w && !(|bend_w));
	coll_c: cover property (ram_coll_w || per_coll_w);
	reload_c: cover property (eng_done && bend_w[cur_ch_r] && !con_r[cur_ch_r][dma_pkg::B_ONE]);
endmodule : eight_channel_peripheral_dma
`default_nettype wire

/* File: periph_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Peripheral registers and buffer RAM seen from the transfer bus.
// ****************************************
module periph_ram_model (
	input wire logic clk_in,
	input wire logic ram_rd_in,
	input wire logic per_rd_in,
	input wire logic ram_wr_in,
	input wire logic per_wr_in,
	input wire logic [15:0] ram_addr_in,
	input wire logic [15:0] per_addr_in,
	input wire logic coll_en_in,
	input wire logic [15:0] ind_addr_in,
	output logic [15:0] ram_rdata_out,
	output logic [15:0] per_rdata_out,
	output logic [15:0] ind_addr_out,
	output logic ram_coll_out,
	output logic per_coll_out
);
	initial ram_rdata_out = 16'h5555;
	initial per_rdata_out = 16'haaaa;
	// Outside a read the data lines flip every cycle, so a late sample shows up at once.
	always @(posedge clk_in) begin
		ram_rdata_out <= ram_rd_in ? (ram_addr_in ^ 16'ha5c3) : ~ram_rdata_out;
		per_rdata_out <= per_rd_in ? (per_addr_in ^ 16'h1e0f) : ~per_rdata_out;
	end
	assign ind_addr_out = ind_addr_in;
	assign ram_coll_out = coll_en_in & ram_wr_in;
	assign per_coll_out = coll_en_in & per_wr_in;
endmodule : periph_ram_model
`default_nettype wire

/* File: eight_channel_peripheral_dma_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) err(nm, ex, gt); end
// ****************************************
// Self-checking bench: drivers queue expected bus events, a monitor pops them.
// ****************************************
module eight_channel_peripheral_dma_tb_top;
	localparam logic [15:0] PD = 16'h0226 ^ 16'h1e0f;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [127:0] req = '0;
	logic coll = 1'b0;
	logic [15:0] ind = 16'h0;
	logic [31:0] prdata;
	logic pready, pslverr, prs, pws, rrs, rws, byt, rcol, pcol;
	logic [15:0] pa, pw, ra, rw, prd, rrd, ia;
	logic [7:0] irq;
	int n_errors = 0;
	int samples_checked = 0;
	logic [35:0] exp_q[$];

	eight_channel_peripheral_dma DUT (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .REQ_LINE_IN(req),
		.PER_IND_ADDR_IN(ia), .PER_RDATA_IN(prd), .RAM_RDATA_IN(rrd), .PER_COLL_IN(pcol),
		.RAM_COLL_IN(rcol), .PER_ADDR_OUT(pa), .PER_WDATA_OUT(pw), .PER_RD_OUT(prs),
		.PER_WR_OUT(pws), .RAM_ADDR_OUT(ra), .RAM_WDATA_OUT(rw), .RAM_RD_OUT(rrs),
		.RAM_WR_OUT(rws), .BYTE_OUT(byt), .CH_IRQ_OUT(irq));
	periph_ram_model PRM (.clk_in(clk), .ram_rd_in(rrs), .per_rd_in(prs), .ram_wr_in(rws),
		.per_wr_in(pws), .ram_addr_in(ra), .per_addr_in(pa), .coll_en_in(coll),
		.ind_addr_in(ind), .ram_rdata_out(rrd), .per_rdata_out(prd), .ind_addr_out(ia),
		.ram_coll_out(rcol), .per_coll_out(pcol));

	initial forever #12.5 clk = ~clk;

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic err(input string nm, input logic [35:0] ex, input logic [35:0] gt);
		n_errors++;
		$display("[ERR] %s expected %h seen %h", nm, ex, gt);
	endtask : err

	function automatic logic [11:0] adr(input int ch, input logic [4:0] o);
		return {dma_pkg::CH_PAGE, 3'(ch), o};
	endfunction : adr

	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
			output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err("ready wait", 36'h1, 36'h0);
			tally_and_finish();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input int ch, input logic [4:0] o, input logic [15:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, adr(ch, o), d, q, e);
	endtask : wr

	task automatic rchk(input logic [11:0] a, input logic [15:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 16'h0, q, e);
		`CHK("register read", {16'h0, x}, q)
	endtask : rchk

	task automatic wait_q();
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) begin
			err("event wait", 36'h0, 36'(exp_q.size()));
			tally_and_finish();
		end
		repeat (4) @(posedge clk);
	endtask : wait_q

	task automatic cfg(input int ch, input logic [15:0] con, sel, primary_buffer_base, stb, cnt);
		wr(ch, dma_pkg::OFS_STA, primary_buffer_base);
		wr(ch, dma_pkg::OFS_STB, stb);
		wr(ch, dma_pkg::OFS_PAD, con[13] ? 16'h0224 : 16'h0226);
		wr(ch, dma_pkg::OFS_CNT, cnt);
		wr(ch, dma_pkg::OFS_REQ, sel);
		wr(ch, dma_pkg::OFS_CON, con);
	endtask : cfg

	task automatic ew(input logic [1:0] k, input logic [15:0] a, input logic [15:0] d);
		exp_q.push_back({k, a, d});
	endtask : ew

	task automatic frc(input int ch);
		wr(ch, dma_pkg::OFS_REQ, 16'h8000);
		wait_q();
	endtask : frc

	task automatic pulse(input logic [127:0] v);
		req <= v;
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		wait_q();
	endtask : pulse

	task automatic pop(input logic [35:0] g);
		logic [35:0] x;
		if (exp_q.size() == 0) begin
			err("unexpected event", 36'h0, g);
		end else begin
			x = exp_q.pop_front();
			`CHK("bus event", x, g)
		end
	endtask : pop

	always @(posedge clk) begin
		if (rst === 1'b0) begin
			if (rws === 1'b1) pop({2'd0, ra, rw});
			if (pws === 1'b1) pop({2'd1, pa, pw});
			if (irq !== 8'h00) pop({2'd2, 8'h0, irq, 16'h0});
		end
	end

	initial begin
		logic [31:0] q;
		logic e;
		logic [6:0] r;
		logic [15:0] b;
		void'($urandom(32'h5618));
		r = 7'($urandom());
		b = 16'($urandom()) & 16'hfffe;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rchk(adr(i, dma_pkg::OFS_CON), 16'h0);
			rchk(adr(i, dma_pkg::OFS_REQ), 16'h0);
		end
		rchk(12'h104, 16'h0f00);
		apb(1'b0, 12'h200, 16'h0, q, e);
		`CHK("error flag", 1'b1, e)
		$display("test reset done");
		cfg(0, 16'h8001, 16'h0, b, 16'h0, 16'h1);
		ew(2'd0, b, PD);
		frc(0);
		rchk(adr(0, dma_pkg::OFS_STA), b + 16'h2);
		ew(2'd0, b + 16'h2, PD);
		ew(2'd2, 16'h0001, 16'h0);
		frc(0);
		rchk(adr(0, dma_pkg::OFS_CON), 16'h0001);
		rchk(adr(0, dma_pkg::OFS_REQ), 16'h0);
		rchk(12'h104, 16'h0000);
		$display("test forced block done");
		cfg(3, 16'he011, {9'h0, r}, 16'h0201, 16'h0, 16'h1);
		pulse(128'h1 << (r + 7'h1));
		for (int i = 0; i < 2; i++) begin
			ew(2'd1, 16'h0224, 16'h00c2);
			if (i == 1) ew(2'd2, 16'h0008, 16'h0);
			pulse(128'h1 << r);
		end
		$display("test request byte done");
		coll <= 1'b1;
		cfg(5, 16'h8801, 16'h0, 16'h0300, 16'h0, 16'h0);
		ew(2'd0, 16'h0300, PD);
		ew(2'd1, 16'h0226, 16'h0);
		ew(2'd2, 16'h0020, 16'h0);
		frc(5);
		coll <= 1'b0;
		rchk(12'h100, 16'h2020);
		apb(1'b1, 12'h100, 16'hffff, q, e);
		rchk(12'h100, 16'h0000);
		$display("test null collision done");
		for (int c = 6; c < 8; c++) begin
			ind <= 16'h0456 + 16'(c);
			cfg(c, 16'h8001 | 16'((c - 4) << 4), 16'h0, 16'h0400, 16'h0, 16'h0);
			ew(2'd0, 16'h0456 + 16'(c), PD);
			ew(2'd2, 16'(1 << c), 16'h0);
			frc(c);
		end
		$display("test indirect done");
		cfg(1, 16'h8000, 16'd10, 16'h0500, 16'h0, 16'h0);
		cfg(2, 16'h8000, 16'd11, 16'h0600, 16'h0, 16'h0);
		ew(2'd0, 16'h0500, PD);
		ew(2'd2, 16'h0002, 16'h0);
		ew(2'd0, 16'h0600, PD);
		ew(2'd2, 16'h0004, 16'h0);
		pulse((128'h1 << 10) | (128'h1 << 11));
		ew(2'd0, 16'h0500, PD);
		ew(2'd2, 16'h0002, 16'h0);
		pulse(128'h1 << 10);
		rchk(12'h104, 16'h0100);
		$display("test priority done");
		cfg(4, 16'h8003, 16'h0, 16'h0700, 16'h0780, 16'h0);
		ew(2'd0, 16'h0700, PD);
		ew(2'd2, 16'h0010, 16'h0);
		frc(4);
		rchk(12'h104, 16'h0410);
		ew(2'd0, 16'h0780, PD);
		ew(2'd2, 16'h0010, 16'h0);
		frc(4);
		rchk(adr(4, dma_pkg::OFS_CON), 16'h0003);
		$display("test ping-pong done");
		cfg(0, 16'h9002, 16'h0, 16'h0800, 16'h0900, 16'h3);
		for (int i = 0; i < 4; i++) begin
			ew(2'd0, 16'h0800 + 16'(2 * i), PD);
			if (i == 1) ew(2'd2, 16'h0001, 16'h0);
			frc(0);
		end
		$display("test half block done");
		tally_and_finish();
	end
endmodule : eight_channel_peripheral_dma_tb_top
`default_nettype wire
